//--- cmo_pkg.sv
// Purpose: shared constants and carriers for the core memory block
// Assumes: one clock, synchronous reset, offsets are in-bank byte offsets
// Notes: program size mask picks the larger variant
package cmo_pkg;
    localparam logic [6:0] OFF_IND0 = 7'h00;
    localparam logic [6:0] OFF_IND1 = 7'h01;
    localparam logic [6:0] OFF_PCL = 7'h02;
    localparam logic [6:0] OFF_STATUS = 7'h03;
    localparam logic [6:0] OFF_PTR0L = 7'h04;
    localparam logic [6:0] OFF_PTR0H = 7'h05;
    localparam logic [6:0] OFF_PTR1L = 7'h06;
    localparam logic [6:0] OFF_PTR1H = 7'h07;
    localparam logic [6:0] OFF_BSR = 7'h08;
    localparam logic [6:0] OFF_WORKING_REGISTER = 7'h09;
    localparam logic [6:0] OFF_PC_HIGH_LATCH = 7'h0A;
    localparam logic [6:0] OFF_INTERRUPT_CONTROL = 7'h0B;
    localparam logic [6:0] OFF_SFR_HI = 7'h1F;
    localparam logic [6:0] OFF_GPR_LO = 7'h20;
    localparam logic [6:0] OFF_GPR_HI = 7'h6F;
    localparam logic [4:0] POWER_CONTROL_REGISTER_BANK = 5'h01;
    localparam logic [6:0] OFF_POWER_CONTROL_REGISTER = 7'h16;
    localparam int POWER_CONTROL_REGISTER_OVF = 7;
    localparam int POWER_CONTROL_REGISTER_UNF = 6;
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int GPR_PER_BANK = 80;
    localparam int GPR_BANKS = 4;
    localparam int COMMON_BYTES = 16;
    localparam int GPR_TOTAL = GPR_BANKS * GPR_PER_BANK;
    localparam int RAM_DEPTH = GPR_TOTAL + COMMON_BYTES;
    localparam int RAM_AW = 9;
    localparam int STK_DEPTH = 16;
    localparam int STK_AW = 4;
    localparam int PC_W = 15;
    localparam logic [4:0] STK_FULL = 5'h10;
    localparam logic [14:0] PM_MASK = 15'h0FFF;
    localparam logic [14:0] RESET_VEC = 15'h0000;
    localparam logic [14:0] INT_VEC = 15'h0004;
    localparam int PTR_PM_BIT = 15;
    localparam logic [15:0] TRAD_TOP = 16'h0FFF;
    localparam logic [15:0] LIN_BASE = 16'h2000;
    localparam logic [15:0] LIN_TOP = 16'(int'(LIN_BASE) + GPR_TOTAL - 1);
    localparam logic [7:0] BYTE_RST = 8'h00;

    typedef enum logic [1:0] {
        ALU_ADD = 2'b00,
        ALU_SUB = 2'b01,
        ALU_LOGIC = 2'b10
    } cmo_alu_op_t;

    typedef enum logic [2:0] {
        RG_NONE = 3'b000,
        RG_CORE = 3'b001,
        RG_SFR = 3'b010,
        RG_POWER_CONTROL_REGISTER = 3'b011,
        RG_GPR = 3'b100,
        RG_PM = 3'b101
    } cmo_region_t;

    typedef struct packed {
        logic step;
        logic jump;
        logic call;
        logic ret;
        logic int_entry;
        logic [10:0] target;
    } cmo_seq_t;

    typedef struct packed {
        logic valid;
        cmo_alu_op_t op;
        logic [7:0] a;
        logic [7:0] b;
    } cmo_alu_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } cmo_sfr_t;
endpackage : cmo_pkg

//--- cmo_ram.sv
// Purpose: small two-port memory with registered read data
// Assumes: addresses stay below DEPTH
// Notes: write-first, a just-written word reads back at once
`timescale 1ns/1ps
module cmo_ram #(
    parameter int W = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clk_sys, // core clock
    input wire logic we, // write enable
    input wire logic [AW-1:0] waddr, // write address
    input wire logic [W-1:0] wdata, // write data
    input wire logic [AW-1:0] raddr, // read address
    output logic [W-1:0] rdata_q // read data, next cycle
);
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // bypass so a push followed by a pop sees the new word
    always_ff @(posedge clk_sys) begin
        if (we && (waddr == raddr)) begin
            rdata_q <= wdata;
        end else begin
            rdata_q <= mem[raddr];
        end
    end
endmodule : cmo_ram

//--- cmo_core_mem.sv
// Purpose: core registers, banking, pointers, stack and pc of an 8-bit core
// Assumes: sequencer and alu requests come from logic on clk_sys
// Notes: one access per cycle on the register port
`timescale 1ns/1ps
module cmo_core_mem
    import cmo_pkg::*;
(
    input wire logic clk_sys, // core clock
    input wire logic srst, // power-up reset
    input wire logic [6:0] reg_addr, // in-bank offset
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, next cycle
    input cmo_seq_t seq_cmd, // pc and stack commands
    input cmo_alu_t alu_req, // alu operands
    output logic [7:0] alu_result_q, // last alu result
    input wire logic wdt_clear, // watchdog clear executed
    input wire logic sleep_exec, // sleep executed
    input wire logic wdt_timeout, // watchdog expired
    input wire logic stack_rst_en, // reset on stack error
    output logic soft_reset_q, // software reset pulse
    output logic extra_cycle_q, // add one instruction cycle
    output logic [14:0] pc_q, // program counter
    output logic [14:0] pm_addr0_q, // program address, pointer 0
    output logic [14:0] pm_addr1_q, // program address, pointer 1
    input wire logic [13:0] pm_data0, // program word, pointer 0
    input wire logic [13:0] pm_data1, // program word, pointer 1
    output cmo_sfr_t sfr_acc_q, // peripheral access
    input wire logic [7:0] sfr_rdata, // peripheral read data
    output logic [7:0] working_register_q, // working register
    output logic [7:0] interrupt_control_q, // interrupt control
    output logic stack_overflow_flag_q, // stack overflow seen
    output logic stack_underflow_flag_q // stack underflow seen
);
    logic [15:0] ptr0_q;
    logic [15:0] ptr1_q;
    logic [4:0] bank_q;
    logic [6:0] pc_high_latch_q;
    logic [2:0] flags_q;
    logic to_q;
    logic pd_q;
    logic [4:0] sp_q;
    logic [4:0] sp_d;
    logic [14:0] pc_d;
    logic [14:0] tos;
    logic ind;
    logic [15:0] ea;
    logic [4:0] ea_bank;
    logic [6:0] ea_off;
    cmo_region_t rg;
    cmo_region_t rsel_q;
    logic [RAM_AW-1:0] ram_idx;
    logic [7:0] ram_q;
    logic [7:0] rdata_q;
    logic [7:0] core_rd;
    logic [13:0] pm_sel;
    logic ram_we;
    logic wr_core;
    logic wr_status;
    logic wr_power_control_register;
    logic push;
    logic pop;
    logic ovf_ev;
    logic unf_ev;
    logic stk_we;
    logic [14:0] push_val;
    logic [7:0] b_eff;
    logic cin;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] res;
    logic [2:0] fl_new;
    logic [2:0] fl_mask;
    logic [2:0] fl_base;

    assign ind = (reg_addr == OFF_IND0) || (reg_addr == OFF_IND1);
    assign ea = !ind ? {4'h0, bank_q, reg_addr} : ((reg_addr == OFF_IND0) ? ptr0_q : ptr1_q);
    assign ea_bank = ea[11:7];
    assign ea_off = ea[6:0];
    assign pm_sel = (reg_addr == OFF_IND0) ? pm_data0 : pm_data1;

    always_comb begin
        rg = RG_NONE;
        ram_idx = '0;
        if (ea[PTR_PM_BIT]) begin
            rg = RG_PM;
        end else if (ea <= TRAD_TOP) begin
            if (ind && (ea_off <= OFF_IND1)) begin
                // a window seen through a pointer is empty, no recursion
                rg = RG_NONE;
            end else if (ea_off <= OFF_INTERRUPT_CONTROL) begin
                rg = RG_CORE;
            end else if (ea_off <= OFF_SFR_HI) begin
                rg = ((ea_bank == POWER_CONTROL_REGISTER_BANK) && (ea_off == OFF_POWER_CONTROL_REGISTER)) ? RG_POWER_CONTROL_REGISTER : RG_SFR;
            end else if (ea_off <= OFF_GPR_HI) begin
                if (int'(ea_bank) < GPR_BANKS) begin
                    rg = RG_GPR;
                    ram_idx = RAM_AW'(int'(ea_bank) * GPR_PER_BANK + int'(ea_off) - int'(OFF_GPR_LO));
                end
            end else begin
                rg = RG_GPR;
                ram_idx = RAM_AW'(GPR_TOTAL + int'(ea_off[3:0]));
            end
        end else if ((ea >= LIN_BASE) && (ea <= LIN_TOP)) begin
            rg = RG_GPR;
            ram_idx = RAM_AW'(ea - LIN_BASE);
        end
    end

    assign ram_we = reg_wr && (rg == RG_GPR);
    assign wr_core = reg_wr && (rg == RG_CORE);
    assign wr_status = wr_core && (ea_off == OFF_STATUS);
    assign wr_power_control_register = reg_wr && (rg == RG_POWER_CONTROL_REGISTER);

    cmo_ram #(
        .W(8),
        .DEPTH(RAM_DEPTH),
        .AW(RAM_AW)
    ) u_gpr (
        .clk_sys(clk_sys),
        .we(ram_we),
        .waddr(ram_idx),
        .wdata(reg_wdata),
        .raddr(ram_idx),
        .rdata_q(ram_q)
    );

    always_comb begin
        unique case (ea_off)
            OFF_PCL: core_rd = pc_q[7:0];
            OFF_STATUS: core_rd = {3'b000, to_q, pd_q, flags_q};
            OFF_PTR0L: core_rd = ptr0_q[7:0];
            OFF_PTR0H: core_rd = ptr0_q[15:8];
            OFF_PTR1L: core_rd = ptr1_q[7:0];
            OFF_PTR1H: core_rd = ptr1_q[15:8];
            OFF_BSR: core_rd = {3'b000, bank_q};
            OFF_WORKING_REGISTER: core_rd = working_register_q;
            OFF_PC_HIGH_LATCH: core_rd = {1'b0, pc_high_latch_q};
            OFF_INTERRUPT_CONTROL: core_rd = interrupt_control_q;
            default: core_rd = BYTE_RST;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rsel_q <= RG_NONE;
            rdata_q <= BYTE_RST;
        end else if (reg_rd) begin
            rsel_q <= rg;
            unique case (rg)
                RG_CORE: rdata_q <= core_rd;
                RG_PM: rdata_q <= pm_sel[7:0];
                RG_POWER_CONTROL_REGISTER: rdata_q <= {stack_overflow_flag_q, stack_underflow_flag_q, 6'b000000};
                default: rdata_q <= BYTE_RST;
            endcase
        end else begin
            rsel_q <= RG_NONE;
        end
    end

    // ram and peripheral data are already one cycle old here
    always_comb begin
        unique case (rsel_q)
            RG_GPR: reg_rdata = ram_q;
            RG_SFR: reg_rdata = sfr_rdata;
            RG_CORE, RG_PM, RG_POWER_CONTROL_REGISTER: reg_rdata = rdata_q;
            default: reg_rdata = BYTE_RST;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sfr_acc_q <= '0;
        end else begin
            sfr_acc_q.wr <= reg_wr && (rg == RG_SFR);
            sfr_acc_q.rd <= reg_rd && (rg == RG_SFR);
            sfr_acc_q.addr <= {ea_bank, ea_off};
            sfr_acc_q.wdata <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            extra_cycle_q <= 1'b0;
        end else begin
            extra_cycle_q <= (reg_rd || reg_wr) && ind && (rg == RG_PM);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ptr0_q <= 16'h0000;
            ptr1_q <= 16'h0000;
        end else if (wr_core) begin
            if (ea_off == OFF_PTR0L) ptr0_q[7:0] <= reg_wdata;
            if (ea_off == OFF_PTR0H) ptr0_q[15:8] <= reg_wdata;
            if (ea_off == OFF_PTR1L) ptr1_q[7:0] <= reg_wdata;
            if (ea_off == OFF_PTR1H) ptr1_q[15:8] <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pm_addr0_q <= RESET_VEC;
            pm_addr1_q <= RESET_VEC;
        end else begin
            pm_addr0_q <= ptr0_q[14:0] & PM_MASK;
            pm_addr1_q <= ptr1_q[14:0] & PM_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bank_q <= 5'h00;
        end else if (wr_core && (ea_off == OFF_BSR)) begin
            bank_q <= reg_wdata[4:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            working_register_q <= BYTE_RST;
            pc_high_latch_q <= 7'h00;
            interrupt_control_q <= BYTE_RST;
        end else if (wr_core) begin
            if (ea_off == OFF_WORKING_REGISTER) working_register_q <= reg_wdata;
            if (ea_off == OFF_PC_HIGH_LATCH) pc_high_latch_q <= reg_wdata[6:0];
            if (ea_off == OFF_INTERRUPT_CONTROL) interrupt_control_q <= reg_wdata;
        end
    end

    assign cin = (alu_req.op == ALU_SUB);
    assign b_eff = cin ? ~alu_req.b : alu_req.b;
    assign sum = {1'b0, alu_req.a} + {1'b0, b_eff} + {8'h00, cin};
    assign nib = {1'b0, alu_req.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    assign res = (alu_req.op == ALU_LOGIC) ? alu_req.a : sum[7:0];
    assign fl_new = {res == 8'h00, nib[4], sum[8]};
    assign fl_mask = (alu_req.op == ALU_LOGIC) ? 3'b100 : 3'b111;
    assign fl_base = wr_status ? reg_wdata[2:0] : flags_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            flags_q <= 3'b000;
            alu_result_q <= BYTE_RST;
        end else if (alu_req.valid) begin
            flags_q <= (fl_base & ~fl_mask) | (fl_new & fl_mask);
            alu_result_q <= res;
        end else begin
            flags_q <= fl_base;
        end
    end

    // expiry and sleep bits ignore writes
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            to_q <= 1'b1;
            pd_q <= 1'b1;
        end else begin
            if (wdt_timeout) to_q <= 1'b0;
            else if (wdt_clear || sleep_exec) to_q <= 1'b1;
            if (sleep_exec) pd_q <= 1'b0;
            else if (wdt_clear) pd_q <= 1'b1;
        end
    end

    // stack pointer, empty at 0, full at 16
    assign push = seq_cmd.call || seq_cmd.int_entry;
    assign pop = seq_cmd.ret && !push;
    assign ovf_ev = push && (sp_q == STK_FULL);
    assign unf_ev = pop && (sp_q == 5'h00);
    assign stk_we = push && !ovf_ev;
    assign push_val = seq_cmd.int_entry ? pc_q : ((pc_q + 15'h0001) & PM_MASK);

    always_comb begin
        sp_d = sp_q;
        if (stk_we) begin
            sp_d = sp_q + 5'h01;
        end else if (pop && !unf_ev) begin
            sp_d = sp_q - 5'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sp_q <= 5'h00;
        end else begin
            sp_q <= sp_d;
        end
    end

    // return addresses kept off data memory
    cmo_ram #(
        .W(PC_W),
        .DEPTH(STK_DEPTH),
        .AW(STK_AW)
    ) u_stack (
        .clk_sys(clk_sys),
        .we(stk_we),
        .waddr(sp_q[STK_AW-1:0]),
        .wdata(push_val),
        .raddr(STK_AW'(sp_d - 5'h01)),
        .rdata_q(tos)
    );

    // sticky flags, set wins over clear
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stack_overflow_flag_q <= 1'b0;
            stack_underflow_flag_q <= 1'b0;
            soft_reset_q <= 1'b0;
        end else begin
            if (ovf_ev) stack_overflow_flag_q <= 1'b1;
            else if (wr_power_control_register && !reg_wdata[POWER_CONTROL_REGISTER_OVF]) stack_overflow_flag_q <= 1'b0;
            if (unf_ev) stack_underflow_flag_q <= 1'b1;
            else if (wr_power_control_register && !reg_wdata[POWER_CONTROL_REGISTER_UNF]) stack_underflow_flag_q <= 1'b0;
            soft_reset_q <= (ovf_ev || unf_ev) && stack_rst_en;
        end
    end

    // every new pc is masked to the array
    always_comb begin
        pc_d = pc_q;
        if (seq_cmd.int_entry) begin
            pc_d = INT_VEC;
        end else if (seq_cmd.call || seq_cmd.jump) begin
            pc_d = {pc_high_latch_q[6:3], seq_cmd.target};
        end else if (seq_cmd.ret) begin
            pc_d = tos;
        end else if (wr_core && (ea_off == OFF_PCL)) begin
            pc_d = {pc_high_latch_q, reg_wdata};
        end else if (seq_cmd.step) begin
            pc_d = pc_q + 15'h0001;
        end
        pc_d = pc_d & PM_MASK;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pc_q <= RESET_VEC;
        end else begin
            pc_q <= pc_d;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    sequence s_call;
        seq_cmd.call && !seq_cmd.int_entry && (sp_q < STK_FULL);
    endsequence
    sequence s_ret;
        seq_cmd.ret && !seq_cmd.call && !seq_cmd.int_entry;
    endsequence

    a_pc_reset_vec: assert property (disable iff (1'b0) srst |=> pc_q == RESET_VEC)
        else $error("pc not at reset vector");
    a_int_vector: assert property (seq_cmd.int_entry |=> pc_q == INT_VEC)
        else $error("interrupt did not vector");
    a_call_return: assert property (s_call ##1 s_ret |=> pc_q == (($past(pc_q, 2) + 15'h0001) & PM_MASK))
        else $error("return address wrong");
    a_stack_ovf: assert property (ovf_ev |=> stack_overflow_flag_q && (soft_reset_q == $past(stack_rst_en)))
        else $error("overflow not flagged");
    a_stack_unf: assert property (unf_ev |=> stack_underflow_flag_q && (soft_reset_q == $past(stack_rst_en)))
        else $error("underflow not flagged");
    a_pm_extra: assert property ((reg_rd || reg_wr) && ind && ea[PTR_PM_BIT] |=> extra_cycle_q)
        else $error("no extra cycle");
    a_pm_read: assert property (reg_rd && ind && ea[PTR_PM_BIT] |=> reg_rdata == $past(pm_sel[7:0]))
        else $error("program byte wrong");
    a_pm_no_write: assert property (reg_wr && ea[PTR_PM_BIT] |-> !ram_we ##1 !sfr_acc_q.wr)
        else $error("program write leaked");
    a_pc_wrap: assert property ((pc_q & ~PM_MASK) == 15'h0000)
        else $error("pc beyond memory");
    a_unimpl_zero: assert property (reg_rd && (rg == RG_NONE) |=> reg_rdata == 8'h00)
        else $error("unimplemented read not zero");
    a_status_top: assert property (reg_rd && !ind && (reg_addr == OFF_STATUS) |=> reg_rdata[7:5] == 3'b000)
        else $error("status top bits set");
    a_status_ro: assert property (wr_status && !wdt_timeout && !wdt_clear && !sleep_exec |=> $stable({to_q, pd_q}))
        else $error("read-only status bit written");
    a_flags_win: assert property (alu_req.valid && (alu_req.op != ALU_LOGIC) && wr_status |=> flags_q == $past(fl_new))
        else $error("written flags beat alu");
    a_sub_equal: assert property (alu_req.valid && (alu_req.op == ALU_SUB) && (alu_req.a == alu_req.b) |=> flags_q == 3'b111)
        else $error("equal subtract flags wrong");
    a_to_timeout: assert property (wdt_timeout |=> !to_q)
        else $error("timeout left expiry bit set");
    a_pd_sleep: assert property (sleep_exec |=> !pd_q && (to_q != $past(wdt_timeout)))
        else $error("sleep bits wrong");
endmodule : cmo_core_mem

//--- cpu_memory_organization_test.sv
// Purpose: self-checking bench for the core memory block
// Assumes: all inputs change by non-blocking assignment at rising edges of clk_sys
// Notes: program words and peripheral data come from simple address functions
`timescale 1ns/1ps
module cpu_memory_organization_test
    import cmo_pkg::*;
;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [6:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic wdt_clear = 1'b0;
    logic sleep_exec = 1'b0;
    logic wdt_timeout = 1'b0;
    logic stack_rst_en = 1'b1;
    cmo_seq_t seq_cmd = '0;
    cmo_alu_t alu_req = '0;
    logic [7:0] reg_rdata, alu_result_q, working_register_q, interrupt_control_q, sfr_rdata;
    logic soft_reset_q, extra_cycle_q, stack_overflow_flag_q, stack_underflow_flag_q;
    logic [14:0] pc_q, pm_addr0_q, pm_addr1_q;
    logic [13:0] pm_data0, pm_data1;
    cmo_sfr_t sfr_acc_q;
    int miscompares = 0;
    int comparisons = 0;

    function automatic logic [13:0] pmw(input logic [14:0] a);
        return a[13:0] ^ 14'h1a5c;
    endfunction : pmw

    assign pm_data0 = pmw(pm_addr0_q);
    assign pm_data1 = pmw(pm_addr1_q);
    // peripheral answer depends on offset and bank bit 0 only, so a wrong bank shows up only when bit 0 differs
    assign sfr_rdata = sfr_acc_q.addr[7:0] ^ 8'h3c;

    initial forever #10 clk_sys = ~clk_sys;

    cmo_core_mem DUT (.clk_sys, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .seq_cmd,
        .alu_req, .alu_result_q, .wdt_clear, .sleep_exec, .wdt_timeout, .stack_rst_en, .soft_reset_q,
        .extra_cycle_q, .pc_q, .pm_addr0_q, .pm_addr1_q, .pm_data0, .pm_data1, .sfr_acc_q, .sfr_rdata,
        .working_register_q, .interrupt_control_q, .stack_overflow_flag_q, .stack_underflow_flag_q);

    task complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [6:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask : rd

    task seq(input logic [4:0] k, input logic [10:0] t);
        @(posedge clk_sys);
        seq_cmd <= cmo_seq_t'({k, t});
        @(posedge clk_sys);
        seq_cmd <= '0;
        #1;
    endtask : seq

    task alu(input cmo_alu_op_t op, input logic [7:0] a, b, input logic stw, input logic [7:0] sv, r, st);
        @(posedge clk_sys);
        alu_req <= '{valid: 1'b1, op: op, a: a, b: b};
        reg_wr <= stw;
        reg_addr <= OFF_STATUS;
        reg_wdata <= sv;
        @(posedge clk_sys);
        alu_req <= '0;
        reg_wr <= 1'b0;
        #1;
        chk(alu_result_q, r);
        rd(OFF_STATUS, st);
    endtask : alu

    task wd(input logic [2:0] m, input logic [7:0] e);
        @(posedge clk_sys);
        {wdt_timeout, sleep_exec, wdt_clear} <= m;
        @(posedge clk_sys);
        {wdt_timeout, sleep_exec, wdt_clear} <= 3'b000;
        #1;
        rd(OFF_STATUS, e);
    endtask : wd

    initial begin
        #1_000_000;
        miscompares++;
        complete_run();
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        rd(OFF_STATUS, 8'h18);
        chk(pc_q, RESET_VEC);
        for (int i = 1; i <= 16; i++) begin
            seq(5'b00100, 11'(i * 16));
            chk(pc_q, 16'(i * 16));
        end
        chk(stack_overflow_flag_q, 1'b0);
        seq(5'b00100, 11'h7ff);
        chk(stack_overflow_flag_q, 1'b1);
        chk(soft_reset_q, 1'b1);
        for (int i = 16; i >= 1; i--) begin
            seq(5'b00010, 11'h000);
            chk(pc_q, 16'((i - 1) * 16 + 1));
        end
        seq(5'b00010, 11'h000);
        chk(stack_underflow_flag_q, 1'b1);
        chk(soft_reset_q, 1'b1);
        wr(OFF_BSR, 8'h01);
        rd(OFF_POWER_CONTROL_REGISTER, 8'hc0);
        wr(OFF_POWER_CONTROL_REGISTER, 8'h00);
        rd(OFF_POWER_CONTROL_REGISTER, 8'h00);
        wr(OFF_PC_HIGH_LATCH, 8'h05);
        wr(OFF_PCL, 8'h34);
        chk(pc_q, 16'h0534);
        seq(5'b00001, 11'h000);
        chk(pc_q, INT_VEC);
        seq(5'b00010, 11'h000);
        chk(pc_q, 16'h0534);
        wr(OFF_PC_HIGH_LATCH, 8'h7f);
        wr(OFF_PCL, 8'hff);
        chk(pc_q, 16'h0fff);
        seq(5'b10000, 11'h000);
        chk(pc_q, 16'h0000);
        seq(5'b00100, 11'h123);
        chk(pc_q, 16'h0923);
        wr(OFF_WORKING_REGISTER, 8'h5a);
        chk(working_register_q, 8'h5a);
        rd(OFF_WORKING_REGISTER, 8'h5a);
        wr(OFF_INTERRUPT_CONTROL, 8'ha5);
        chk(interrupt_control_q, 8'ha5);
        wr(OFF_BSR, 8'hff);
        rd(OFF_BSR, 8'h1f);
        wr(OFF_STATUS, 8'hff);
        rd(OFF_STATUS, 8'h1f);
        wr(OFF_STATUS, 8'h00);
        rd(OFF_STATUS, 8'h18);
        alu(ALU_ADD, 8'h0f, 8'h01, 1'b0, 8'h00, 8'h10, 8'h1a);
        alu(ALU_ADD, 8'hff, 8'h01, 1'b0, 8'h00, 8'h00, 8'h1f);
        alu(ALU_SUB, 8'h05, 8'h05, 1'b0, 8'h00, 8'h00, 8'h1f);
        alu(ALU_SUB, 8'h03, 8'h05, 1'b0, 8'h00, 8'hfe, 8'h18);
        alu(ALU_LOGIC, 8'h00, 8'h00, 1'b0, 8'h00, 8'h00, 8'h1c);
        alu(ALU_ADD, 8'hff, 8'h01, 1'b1, 8'h00, 8'h00, 8'h1f);
        alu(ALU_LOGIC, 8'h01, 8'h00, 1'b1, 8'h03, 8'h01, 8'h1b);
        wd(3'b100, 8'h0b);
        wd(3'b010, 8'h13);
        wd(3'b001, 8'h1b);
        wd(3'b101, 8'h0b);
        wr(OFF_BSR, 8'h01);
        wr(OFF_GPR_LO, 8'h11);
        wr(OFF_BSR, 8'h02);
        wr(OFF_GPR_LO, 8'h22);
        wr(7'h70, 8'h77);
        wr(OFF_BSR, 8'h01);
        rd(OFF_GPR_LO, 8'h11);
        wr(OFF_BSR, 8'h00);
        rd(7'h70, 8'h77);
        wr(OFF_BSR, 8'h05);
        rd(OFF_GPR_LO, 8'h00);
        wr(OFF_PTR0H, 8'h20);
        wr(OFF_PTR0L, 8'h50);
        rd(OFF_IND0, 8'h11);
        chk(pm_addr0_q, 16'h0050);
        chk(extra_cycle_q, 1'b0);
        wr(OFF_IND0, 8'h44);
        wr(OFF_BSR, 8'h01);
        rd(OFF_GPR_LO, 8'h44);
        wr(OFF_BSR, 8'h03);
        rd(7'h0c, 8'hb0);
        chk(sfr_acc_q.addr, 12'h18c);
        chk(sfr_acc_q.rd, 1'b1);
        wr(OFF_SFR_HI, 8'h66);
        chk({sfr_acc_q.wr, sfr_acc_q.addr}, 13'h119f);
        chk(sfr_acc_q.wdata, 8'h66);
        wr(OFF_PTR1H, 8'h81);
        wr(OFF_PTR1L, 8'h23);
        rd(OFF_IND1, 8'(pmw(15'h0123)));
        chk(extra_cycle_q, 1'b1);
        chk(pm_addr1_q, 16'h0123);
        wr(OFF_PTR1H, 8'h9f);
        rd(OFF_IND1, 8'(pmw(15'h0f23)));
        wr(OFF_IND1, 8'h99);
        chk(extra_cycle_q, 1'b1);
        rd(OFF_IND1, 8'(pmw(15'h0f23)));
        wr(OFF_BSR, 8'h01);
        rd(OFF_GPR_LO, 8'h44);
        complete_run();
    end
endmodule : cpu_memory_organization_test
